// file: verilog/gpm_pinmux.sv
`timescale 1ns/1ps
`include "gpm_cfg.svh"
module gpm_pinmux
(
	input  wire logic        clk,                    // System clock
	input  wire logic        rst,                    // Async reset
	input  wire logic [15:0] bus_addr,               // 16-bit word address
	input  wire logic        bus_wr,                 // Write strobe
	input  wire logic        bus_rd,                 // Read strobe
	input  wire logic        bus_wide,               // 32-bit access
	input  wire logic [31:0] bus_wdata,              // Write data
	output logic      [31:0] bus_rdata,              // Read data
	input  wire logic        protected_write_permit, // Protected writes on
	input  wire logic [31:0] pin_a_in,               // Port A pad levels
	output logic      [31:0] pin_a_out,              // Port A pad data
	output logic      [31:0] pin_a_oe_n,             // Port A drive, low on
	output logic      [31:0] pin_a_pull_en,          // Port A pull-ups
	input  wire logic [6:0]  pin_b_in,               // Port B pad levels
	output logic      [6:0]  pin_b_out,              // Port B pad data
	output logic      [6:0]  pin_b_oe_n,             // Port B drive, low on
	output logic      [6:0]  pin_b_pull_en,          // Port B pull-ups
	input  wire logic [15:0] aio_in,                 // Analog pin levels
	output logic      [15:0] aio_out,                // Analog pin data
	output logic      [15:0] aio_oe_n,               // Analog drive, low on
	output logic      [15:0] aio_analog,             // Analog function on
	input  wire logic [7:0]  pwm_ch_out,             // PWM 1A,1B..4A,4B
	input  wire logic        comparator_1_output,    // Comparator 1
	input  wire logic        comparator_2_output,    // Comparator 2
	input  wire logic        pwm_sync_out,           // PWM sync out
	input  wire logic        serial_transmit,        // Serial TX
	input  wire logic        clock_output_pin,       // Clock out
	input  wire logic        spi_data_out_in_o,      // SPI data out
	input  wire logic        spi_data_out_in_drive,  // SPI data out enable
	input  wire logic        spi_data_in_out_o,      // SPI data in line
	input  wire logic        spi_data_in_out_drive,  // Its enable
	input  wire logic        spi_clock_pin_o,        // SPI clock
	input  wire logic        spi_clock_pin_drive,    // Its enable
	input  wire logic        spi_select_pin_o,       // SPI select
	input  wire logic        spi_select_pin_drive,   // Its enable
	input  wire logic        i2c_data_pin_low,       // Pull I2C data low
	input  wire logic        i2c_clock_pin_low,      // Pull I2C clock low
	input  wire logic        capture_pin_o,          // Capture output
	input  wire logic        capture_pin_drive,      // Its enable
	output logic             pwm_sync_in,            // PWM sync in
	output logic             serial_receive,         // Serial RX
	output logic             trip_input_1,           // Trip 1
	output logic             trip_input_2,           // Trip 2
	output logic             trip_input_3,           // Trip 3
	output logic             spi_data_out_in_i,      // SPI data out line
	output logic             spi_data_in_out_i,      // SPI data in line
	output logic             spi_clock_pin_i,        // SPI clock
	output logic             spi_select_pin_i,       // SPI select
	output logic             i2c_data_pin_i,         // I2C data
	output logic             i2c_clock_pin_i,        // I2C clock
	output logic             capture_pin_i,          // Capture input
	output logic             ext_irq_line_1,         // Interrupt line 1
	output logic             ext_irq_line_2,         // Interrupt line 2
	output logic             ext_irq_line_3,         // Interrupt line 3
	output logic      [31:0] low_power_wake_sel      // Wake-capable pins
);
	logic [31:0] ctrl_a_reg;
	logic [31:0] qlo_a_reg;
	logic [31:0] qhi_a_reg;
	logic [31:0] mlo_a_reg;
	logic [31:0] mhi_a_reg;
	logic [31:0] dir_a_reg;
	logic [31:0] pud_a_reg;
	logic [31:0] ctrl_b_reg;
	logic [31:0] q_b_reg;
	logic [31:0] m_b_reg;
	logic [31:0] dir_b_reg;
	logic [31:0] pud_b_reg;
	logic [31:0] m_n_reg;
	logic [31:0] dir_n_reg;
	logic [31:0] lat_a_reg;
	logic [31:0] lat_b_reg;
	logic [31:0] lat_n_reg;
	logic [4:0]  irq_sel_reg [3];
	logic [31:0] wake_reg;
	logic [2:0]  irq_reg;
	logic [7:0]  cnt_reg [5];
	logic [4:0]  smp_en;
	logic [31:0] rd_word;
	logic [31:0] mlo_e;
	logic [31:0] mhi_e;
	logic [31:0] qlo_e;
	logic [31:0] qhi_e;
	logic [31:0] mb_e;
	logic [31:0] qb_e;
	logic [31:0] mn_e;
	wire  logic [31:0] qa;
	wire  logic [31:0] qb;
	wire  logic [31:0] qn;
	wire  logic [63:0] m_e = {mhi_e, mlo_e};
	wire  logic [63:0] q_e = {qhi_e, qlo_e};
	logic [31:0] a_o;
	logic [31:0] a_d;
	logic        wp;

	// Merge a write into an old word
	function automatic logic [31:0] upd(input logic [31:0] old);
		if (bus_wide)
			upd = bus_wdata;
		else if (bus_addr[0])
			upd = {bus_wdata[15:0], old[15:0]};
		else
			upd = {old[31:16], bus_wdata[15:0]};
	endfunction : upd

	// Either half of a 32-bit register hits
	function automatic logic hit(input logic [15:0] base);
		hit = ({bus_addr[15:1], 1'b0} == base);
	endfunction : hit

	// Latch update from value/set/clear/invert
	function automatic logic [31:0] lat_upd(input logic [31:0] old, input logic [15:0] v,
		input logic [15:0] s, input logic [15:0] c, input logic [15:0] t);
		logic [31:0] ones;
		ones = upd(`GPM_RST_ZERO);
		lat_upd = old;
		if (bus_wr && hit(v))
			lat_upd = upd(old);
		if (bus_wr && hit(s))
			lat_upd = old | ones;
		if (bus_wr && hit(c))
			lat_upd = old & ~ones;
		if (bus_wr && hit(t))
			lat_upd = old ^ ones;
	endfunction : lat_upd

	// Function code of a port A pin as now in force
	function automatic gpm_pkg::gpm_fn_t code_a(input int i);
		code_a = gpm_pkg::gpm_fn_t'(m_e[2*i +: 2]);
	endfunction : code_a

	// Qualified level when selected, else idle high
	function automatic logic in_a(input int i, input gpm_pkg::gpm_fn_t c);
		in_a = (code_a(i) == c) ? qa[i] : `GPM_IDLE_IN;
	endfunction : in_a

	// Sampling period of a group of eight pins
	function automatic logic [7:0] per(input int g);
		per = (g < 4) ? ctrl_a_reg[8*g +: 8] : ctrl_b_reg[7:0];
	endfunction : per

	assign wp = bus_wr & protected_write_permit;

	// Protected registers drop writes without permit
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ctrl_a_reg <= `GPM_RST_ZERO;
			qlo_a_reg <= `GPM_RST_ZERO;
			qhi_a_reg <= `GPM_RST_ZERO;
			mlo_a_reg <= `GPM_RST_ZERO;
			mhi_a_reg <= `GPM_RST_ZERO;
			dir_a_reg <= `GPM_RST_ZERO;
			pud_a_reg <= `GPM_RST_ZERO;
			ctrl_b_reg <= `GPM_RST_ZERO;
			q_b_reg <= `GPM_RST_ZERO;
			m_b_reg <= `GPM_RST_ZERO;
			dir_b_reg <= `GPM_RST_ZERO;
			pud_b_reg <= `GPM_RST_ZERO;
			m_n_reg <= `GPM_RST_ZERO;
			dir_n_reg <= `GPM_RST_ZERO;
		end
		else if (wp)
		begin
			if (hit(`GPM_A_CTRL))
				ctrl_a_reg <= upd(ctrl_a_reg);
			if (hit(`GPM_A_QLO))
				qlo_a_reg <= upd(qlo_a_reg);
			if (hit(`GPM_A_QHI))
				qhi_a_reg <= upd(qhi_a_reg);
			if (hit(`GPM_A_MLO))
				mlo_a_reg <= upd(mlo_a_reg) & `GPM_A_MLO_IMPL;
			if (hit(`GPM_A_MHI))
				mhi_a_reg <= upd(mhi_a_reg) & `GPM_A_MHI_IMPL;
			if (hit(`GPM_A_DIR))
				dir_a_reg <= upd(dir_a_reg) & `GPM_A_IMPL;
			if (hit(`GPM_A_PUD))
				pud_a_reg <= upd(pud_a_reg) & `GPM_A_IMPL;
			if (hit(`GPM_B_CTRL))
				ctrl_b_reg <= upd(ctrl_b_reg);
			if (hit(`GPM_B_QSEL))
				q_b_reg <= upd(q_b_reg) & `GPM_B_MUX_IMPL;
			if (hit(`GPM_B_MUX))
				m_b_reg <= upd(m_b_reg) & `GPM_B_MUX_IMPL;
			if (hit(`GPM_B_DIR))
				dir_b_reg <= upd(dir_b_reg) & `GPM_B_IMPL;
			if (hit(`GPM_B_PUD))
				pud_b_reg <= upd(pud_b_reg) & `GPM_B_IMPL;
			if (hit(`GPM_N_MUX))
				m_n_reg <= upd(m_n_reg);
			if (hit(`GPM_N_DIR))
				dir_n_reg <= upd(dir_n_reg) & `GPM_N_IMPL;
		end
	end

	// Interrupt source and wake selects, also permit-gated
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			for (int k = 0; k < 3; k++)
				irq_sel_reg[k] <= 5'h00;
			wake_reg <= `GPM_RST_ZERO;
		end
		else if (wp)
		begin
			if (bus_addr == `GPM_IRQ1)
				irq_sel_reg[0] <= bus_wdata[4:0];
			if (bus_addr == `GPM_IRQ2)
				irq_sel_reg[1] <= bus_wdata[4:0];
			if (bus_addr == `GPM_IRQ3)
				irq_sel_reg[2] <= bus_wdata[4:0];
			if (hit(`GPM_WAKE))
				wake_reg <= upd(wake_reg) & `GPM_A_IMPL;
		end
	end

	// Output latches need no permit
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			lat_a_reg <= `GPM_RST_ZERO;
			lat_b_reg <= `GPM_RST_ZERO;
			lat_n_reg <= `GPM_RST_ZERO;
		end
		else
		begin
			lat_a_reg <= lat_upd(lat_a_reg, `GPM_A_VAL, `GPM_A_SET, `GPM_A_CLR, `GPM_A_TOG) & `GPM_A_IMPL;
			lat_b_reg <= lat_upd(lat_b_reg, `GPM_B_VAL, `GPM_B_SET, `GPM_B_CLR, `GPM_B_TOG) & `GPM_B_IMPL;
			lat_n_reg <= lat_upd(lat_n_reg, `GPM_N_VAL, `GPM_N_SET, `GPM_N_CLR, `GPM_N_TOG) & `GPM_N_IMPL;
		end
	end

	// New settings take hold two cycles late
	gpm_delay #(
		.W (224),
		.N (`GPM_SEL_DELAY)
	) u_sel_delay (
		.clk (clk),
		.rst (rst),
		.d   ({mlo_a_reg, mhi_a_reg, qlo_a_reg, qhi_a_reg, m_b_reg, q_b_reg, m_n_reg}),
		.q   ({mlo_e, mhi_e, qlo_e, qhi_e, mb_e, qb_e, mn_e})
	);

	// Tick every max(period,1) cycles per group
	always_comb
	begin
		for (int g = 0; g < 5; g++)
			smp_en[g] = ({1'b0, cnt_reg[g]} + 9'h001) >= {1'b0, per(g)};
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			for (int g = 0; g < 5; g++)
				cnt_reg[g] <= 8'h00;
		end
		else
		begin
			for (int g = 0; g < 5; g++)
				cnt_reg[g] <= smp_en[g] ? 8'h00 : cnt_reg[g] + 8'h01;
		end
	end

	// Analog pins only get synchronised
	for (genvar i = 0; i < 32; i++)
	begin : g_qa
		gpm_qual u_q (
			.clk    (clk),
			.rst    (rst),
			.pin    (pin_a_in[i]),
			.mode   (gpm_pkg::gpm_qual_t'(q_e[2*i +: 2])),
			.smp_en (smp_en[i/8]),
			.q      (qa[i])
		);
	end
	for (genvar i = 0; i < 7; i++)
	begin : g_qb
		gpm_qual u_q (
			.clk    (clk),
			.rst    (rst),
			.pin    (pin_b_in[i]),
			.mode   (gpm_pkg::gpm_qual_t'(qb_e[2*i +: 2])),
			.smp_en (smp_en[4]),
			.q      (qb[i])
		);
	end
	for (genvar i = 0; i < 16; i++)
	begin : g_qn
		gpm_qual u_q (
			.clk    (clk),
			.rst    (rst),
			.pin    (aio_in[i]),
			.mode   (gpm_pkg::QUAL_SYNC),
			.smp_en (1'b0),
			.q      (qn[i])
		);
	end
	assign qb[31:7] = '0;
	assign qn[31:16] = '0;

	// Port A drive; reserved codes leave pads undriven
	always_comb
	begin
		for (int i = 0; i < 32; i++)
		begin
			a_o[i] = lat_a_reg[i];
			a_d[i] = dir_a_reg[i] && code_a(i) == gpm_pkg::FN_GPIO;
			if (code_a(i) != gpm_pkg::FN_GPIO)
				a_o[i] = 1'b0;
		end
		for (int i = 0; i < 8; i++)
			if (code_a(i) == gpm_pkg::FN_SEL1)
				{a_o[i], a_d[i]} = {pwm_ch_out[i], 1'b1};
		if (code_a(1) == gpm_pkg::FN_SEL3)
			{a_o[1], a_d[1]} = {comparator_1_output, 1'b1};
		if (code_a(3) == gpm_pkg::FN_SEL3)
			{a_o[3], a_d[3]} = {comparator_2_output, 1'b1};
		if (code_a(5) == gpm_pkg::FN_SEL3)
			{a_o[5], a_d[5]} = {capture_pin_o, capture_pin_drive};
		if (code_a(6) == gpm_pkg::FN_SEL3)
			{a_o[6], a_d[6]} = {pwm_sync_out, 1'b1};
		if (code_a(12) == gpm_pkg::FN_SEL2)
			{a_o[12], a_d[12]} = {serial_transmit, 1'b1};
		if (code_a(16) == gpm_pkg::FN_SEL1)
			{a_o[16], a_d[16]} = {spi_data_out_in_o, spi_data_out_in_drive};
		if (code_a(17) == gpm_pkg::FN_SEL1)
			{a_o[17], a_d[17]} = {spi_data_in_out_o, spi_data_in_out_drive};
		if (code_a(18) == gpm_pkg::FN_SEL1)
			{a_o[18], a_d[18]} = {spi_clock_pin_o, spi_clock_pin_drive};
		if (code_a(18) == gpm_pkg::FN_SEL2)
			{a_o[18], a_d[18]} = {serial_transmit, 1'b1};
		if (code_a(18) == gpm_pkg::FN_SEL3)
			{a_o[18], a_d[18]} = {clock_output_pin, 1'b1};
		if (code_a(19) == gpm_pkg::FN_SEL1)
			{a_o[19], a_d[19]} = {spi_select_pin_o, spi_select_pin_drive};
		if (code_a(19) == gpm_pkg::FN_SEL3)
			{a_o[19], a_d[19]} = {capture_pin_o, capture_pin_drive};
		if (code_a(28) == gpm_pkg::FN_SEL2)
			{a_o[28], a_d[28]} = {1'b0, i2c_data_pin_low};
		if (code_a(29) == gpm_pkg::FN_SEL1)
			{a_o[29], a_d[29]} = {serial_transmit, 1'b1};
		if (code_a(29) == gpm_pkg::FN_SEL2)
			{a_o[29], a_d[29]} = {1'b0, i2c_clock_pin_low};
	end

	assign pin_a_out = a_o;
	assign pin_a_oe_n = ~(a_d & `GPM_A_IMPL);
	assign pin_a_pull_en = ~pud_a_reg & `GPM_A_IMPL;

	// Port B: only the I/O code drives the pad; analog pins drive under codes 00 and 01
	always_comb
	begin
		for (int i = 0; i < 7; i++)
		begin
			pin_b_out[i] = lat_b_reg[i];
			pin_b_oe_n[i] = ~(dir_b_reg[i] && mb_e[2*i +: 2] == gpm_pkg::FN_GPIO);
		end
		for (int i = 0; i < 16; i++)
		begin
			aio_analog[i] = mn_e[2*i+1];
			aio_out[i] = lat_n_reg[i];
			aio_oe_n[i] = ~(dir_n_reg[i] & ~mn_e[2*i+1]);
		end
	end
	assign pin_b_pull_en = ~pud_b_reg[6:0];

	// Peripheral inputs idle high when unrouted
	assign pwm_sync_in = in_a(6, gpm_pkg::FN_SEL2);
	assign serial_receive = in_a(7, gpm_pkg::FN_SEL2) & in_a(19, gpm_pkg::FN_SEL2) & in_a(28, gpm_pkg::FN_SEL1);
	assign trip_input_1 = in_a(12, gpm_pkg::FN_SEL1);
	assign trip_input_2 = in_a(16, gpm_pkg::FN_SEL3) & in_a(28, gpm_pkg::FN_SEL3);
	assign trip_input_3 = in_a(17, gpm_pkg::FN_SEL3) & in_a(29, gpm_pkg::FN_SEL3);
	assign spi_data_out_in_i = in_a(16, gpm_pkg::FN_SEL1);
	assign spi_data_in_out_i = in_a(17, gpm_pkg::FN_SEL1);
	assign spi_clock_pin_i = in_a(18, gpm_pkg::FN_SEL1);
	assign spi_select_pin_i = in_a(19, gpm_pkg::FN_SEL1);
	assign i2c_data_pin_i = in_a(28, gpm_pkg::FN_SEL2);
	assign i2c_clock_pin_i = in_a(29, gpm_pkg::FN_SEL2);
	assign capture_pin_i = in_a(5, gpm_pkg::FN_SEL3) & in_a(19, gpm_pkg::FN_SEL3);

	// Interrupt lines follow the selected pin a cycle late
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			irq_reg <= 3'h0;
		else
		begin
			for (int k = 0; k < 3; k++)
				irq_reg[k] <= qa[irq_sel_reg[k]];
		end
	end
	assign ext_irq_line_1 = irq_reg[0];
	assign ext_irq_line_2 = irq_reg[1];
	assign ext_irq_line_3 = irq_reg[2];
	assign low_power_wake_sel = wake_reg;

	// Set/clear/invert and unmapped addresses read zero
	always_comb
	begin
		unique case ({bus_addr[15:1], 1'b0})
			`GPM_A_CTRL: rd_word = ctrl_a_reg;
			`GPM_A_QLO:  rd_word = qlo_a_reg;
			`GPM_A_QHI:  rd_word = qhi_a_reg;
			`GPM_A_MLO:  rd_word = mlo_a_reg;
			`GPM_A_MHI:  rd_word = mhi_a_reg;
			`GPM_A_DIR:  rd_word = dir_a_reg;
			`GPM_A_PUD:  rd_word = pud_a_reg;
			`GPM_B_CTRL: rd_word = ctrl_b_reg;
			`GPM_B_QSEL: rd_word = q_b_reg;
			`GPM_B_MUX:  rd_word = m_b_reg;
			`GPM_B_DIR:  rd_word = dir_b_reg;
			`GPM_B_PUD:  rd_word = pud_b_reg;
			`GPM_N_MUX:  rd_word = m_n_reg;
			`GPM_N_DIR:  rd_word = dir_n_reg;
			`GPM_A_VAL:  rd_word = qa & `GPM_A_IMPL;
			`GPM_B_VAL:  rd_word = qb;
			`GPM_N_VAL:  rd_word = qn;
			`GPM_WAKE:   rd_word = wake_reg;
			default:     rd_word = `GPM_RST_ZERO;
		endcase
		// 16-bit selects sit in both halves so odd addresses read right
		if (bus_addr == `GPM_IRQ1)
			rd_word = {2{11'h000, irq_sel_reg[0]}};
		if (bus_addr == `GPM_IRQ2)
			rd_word = {2{11'h000, irq_sel_reg[1]}};
		if (bus_addr == `GPM_IRQ3)
			rd_word = {2{11'h000, irq_sel_reg[2]}};
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			bus_rdata <= `GPM_RST_ZERO;
		else if (bus_rd)
			bus_rdata <= bus_wide ? rd_word : {16'h0000, bus_addr[0] ? rd_word[31:16] : rd_word[15:0]};
	end
endmodule : gpm_pinmux

// file: verilog/gpm_cfg.svh
`ifndef GPM_CFG_SVH
`define GPM_CFG_SVH
// How it works
// - Every pin offers independent software bit I/O.
// - Twenty-two digital pins across ports A and B.
// - Registers accept 32-bit and 16-bit accesses.
// - Config writes need protected write permission.
// - Interrupt and wake selects need permission too.
// - Function and qualifier changes act two cycles later.
// - Two-bit function field per pin, 00 is I/O.
// - Pins 0-7 route PWM, comparators, capture, sync, serial.
// - Pins 16-19, 28, 29 route SPI, serial, I2C, trips.
// - Pin 12 trip or transmit; others reserved.
// - Direction bit per pin selects drive or read.
// - Set pull-up disable bit removes pull-up.
// - Port B mirrors port A register set.
// - Value read gives pins; write loads latch.
// - Set register ones drive latch bits high.
// - Clear register ones drive latch bits low.
// - Toggle register ones invert latch bits.
// - Sixteen analog-capable pins with digital I/O registers.
// - Three selects pick pin for each interrupt line.
// - Wake select marks pins allowed to wake.
// - Two-bit qualifier field per pin, two registers.
// - Sync only, 3 or 6 samples, or raw.
// - Control bytes set sampling period per eight pins.
`define GPM_A_CTRL     16'h6F80
`define GPM_A_QLO      16'h6F82
`define GPM_A_QHI      16'h6F84
`define GPM_A_MLO      16'h6F86
`define GPM_A_MHI      16'h6F88
`define GPM_A_DIR      16'h6F8A
`define GPM_A_PUD      16'h6F8C
`define GPM_B_CTRL     16'h6F90
`define GPM_B_QSEL     16'h6F92
`define GPM_B_MUX      16'h6F96
`define GPM_B_DIR      16'h6F9A
`define GPM_B_PUD      16'h6F9C
`define GPM_N_MUX      16'h6FB6
`define GPM_N_DIR      16'h6FBA
`define GPM_A_VAL      16'h6FC0
`define GPM_A_SET      16'h6FC2
`define GPM_A_CLR      16'h6FC4
`define GPM_A_TOG      16'h6FC6
`define GPM_B_VAL      16'h6FC8
`define GPM_B_SET      16'h6FCA
`define GPM_B_CLR      16'h6FCC
`define GPM_B_TOG      16'h6FCE
`define GPM_N_VAL      16'h6FD8
`define GPM_N_SET      16'h6FDA
`define GPM_N_CLR      16'h6FDC
`define GPM_N_TOG      16'h6FDE
`define GPM_IRQ1       16'h6FE0
`define GPM_IRQ2       16'h6FE1
`define GPM_IRQ3       16'h6FE2
`define GPM_WAKE       16'h6FE8
`define GPM_A_IMPL     32'h300F10FF
`define GPM_A_MLO_IMPL 32'h0300FFFF
`define GPM_A_MHI_IMPL 32'h0F0000FF
`define GPM_B_IMPL     32'h0000007F
`define GPM_B_MUX_IMPL 32'h00003FFF
`define GPM_N_IMPL     32'h0000FFFF
`define GPM_RST_ZERO   32'h00000000
`define GPM_SEL_DELAY  2
`define GPM_IDLE_IN    1'b1
`endif

// file: verilog/gpm_pkg.sv
package gpm_pkg;
	// Pin function codes
	typedef enum logic [1:0] {FN_GPIO, FN_SEL1, FN_SEL2, FN_SEL3} gpm_fn_t;
	// Input qualifier codes
	typedef enum logic [1:0] {QUAL_SYNC, QUAL_3, QUAL_6, QUAL_RAW} gpm_qual_t;
endpackage : gpm_pkg

// file: verilog/gpm_delay.sv
`timescale 1ns/1ps
`include "gpm_cfg.svh"
module gpm_delay
#(
	parameter int W = 8,             // Width
	parameter int N = `GPM_SEL_DELAY // Stages
)
(
	input  wire logic         clk, // System clock
	input  wire logic         rst, // Async reset
	input  wire logic [W-1:0] d,   // New setting
	output logic      [W-1:0] q    // Setting in force
);
	logic [W-1:0] stage_reg [N];

	// Settings ripple through N stages before use
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			for (int i = 0; i < N; i++)
				stage_reg[i] <= '0;
		end
		else
		begin
			stage_reg[0] <= d;
			for (int i = 1; i < N; i++)
				stage_reg[i] <= stage_reg[i-1];
		end
	end
	assign q = stage_reg[N-1];
endmodule : gpm_delay

// file: verilog/gpm_qual.sv
`timescale 1ns/1ps
module gpm_qual
(
	input  wire logic               clk,    // System clock
	input  wire logic               rst,    // Async reset
	input  wire logic               pin,    // Raw pin level
	input  wire gpm_pkg::gpm_qual_t mode,   // Qualifier code
	input  wire logic               smp_en, // Sampling tick
	output logic                    q       // Qualified level
);
	logic       s1_reg;
	logic       s2_reg;
	logic       s3_reg;
	logic       lvl_reg;
	logic [5:0] hist_reg;
	logic       filt_reg;

	// Three flops; a change counts once s2 and s3 agree
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
			lvl_reg <= 1'b0;
		end
		else
		begin
			s1_reg <= pin;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg)
				lvl_reg <= s3_reg;
		end
	end

	// Output moves only when all samples agree
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			hist_reg <= 6'h00;
			filt_reg <= 1'b0;
		end
		else if (smp_en)
		begin
			hist_reg <= {hist_reg[4:0], lvl_reg};
			if (mode == gpm_pkg::QUAL_3 && hist_reg[2:0] == 3'h7)
				filt_reg <= 1'b1;
			else if (mode == gpm_pkg::QUAL_3 && hist_reg[2:0] == 3'h0)
				filt_reg <= 1'b0;
			else if (mode == gpm_pkg::QUAL_6 && hist_reg == 6'h3F)
				filt_reg <= 1'b1;
			else if (mode == gpm_pkg::QUAL_6 && hist_reg == 6'h00)
				filt_reg <= 1'b0;
		end
	end

	// Raw mode skips synchronising; the peripheral must do it
	always_comb
	begin
		unique case (mode)
			gpm_pkg::QUAL_SYNC: q = lvl_reg;
			gpm_pkg::QUAL_3:    q = filt_reg;
			gpm_pkg::QUAL_6:    q = filt_reg;
			gpm_pkg::QUAL_RAW:  q = pin;
		endcase
	end
endmodule : gpm_qual

// file: bench/gpm_pinmux_props.sv
`timescale 1ns/1ps
`include "gpm_cfg.svh"
module gpm_pinmux_props
(
	input wire logic        clk, // Clock
	input wire logic        rst, // Reset
	input wire logic [15:0] bus_addr, // Address
	input wire logic        bus_wr, // Write
	input wire logic        bus_rd, // Read
	input wire logic        bus_wide, // 32-bit
	input wire logic [31:0] bus_wdata, // Write data
	input wire logic [31:0] bus_rdata, // Read data
	input wire logic        protected_write_permit, // Permit
	input wire logic [31:0] pin_a_out, // Pad data
	input wire logic [31:0] pin_a_oe_n, // Drive, low on
	input wire logic [31:0] pin_a_pull_en, // Pull-ups
	input wire logic [7:0]  pwm_ch_out, // PWM
	input wire logic [31:0] low_power_wake_sel // Wake
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_rdata_hold: assert property (!bus_rd |=> $stable(bus_rdata))
		else $error("read data moved");
	a_setreg_zero: assert property (bus_rd && bus_addr[15:3] == 13'h0DF8 && bus_addr[2:1] != 2'b00
		|=> bus_rdata == 32'h00000000) else $error("bit op read not zero");
	a_pud_load: assert property (bus_wr && protected_write_permit && bus_wide && bus_addr == 16'h6F8C
		|=> pin_a_pull_en == (~$past(bus_wdata) & `GPM_A_IMPL)) else $error("pull-up load wrong");
	a_pud_half: assert property (bus_wr && protected_write_permit && !bus_wide && bus_addr == 16'h6F8D
		|=> pin_a_pull_en[15:0] == $past(pin_a_pull_en[15:0])
		&& pin_a_pull_en[31:16] == (~$past(bus_wdata[15:0]) & 16'h300F)) else $error("half write wrong");
	a_pud_locked: assert property (bus_wr && !protected_write_permit && bus_addr[15:1] == 15'h37C6
		|=> $stable(pin_a_pull_en)) else $error("pull-up unlocked");
	a_wake_locked: assert property (bus_wr && !protected_write_permit && bus_addr[15:1] == 15'h37F4
		|=> $stable(low_power_wake_sel)) else $error("wake unlocked");
	a_unimpl_oe: assert property ((pin_a_oe_n | `GPM_A_IMPL) == 32'hFFFFFFFF)
		else $error("missing pin driven");
	a_fn_delay: assert property (bus_wr && protected_write_permit && bus_addr == 16'h6F86 && bus_wdata[1:0] == 2'b01
		##1 (!(bus_wr && bus_addr[15:1] == 15'h37C3))[*2] ##1 1'b1
		|-> pin_a_out[0] == pwm_ch_out[0] && !pin_a_oe_n[0]) else $error("pin 0 not on PWM");
endmodule : gpm_pinmux_props
bind gpm_pinmux gpm_pinmux_props gpm_pinmux_props_inst (.*);

// file: bench/gpm_board.sv
`timescale 1ns/1ps
module gpm_board
#(
	parameter int W = 32 // Pad count
)
(
	input wire logic         clk, // Clock
	input wire logic [W-1:0] out, // Pad data
	input wire logic [W-1:0] oe_n, // Drive, low on
	input wire logic [W-1:0] pull, // Pull-ups
	input wire logic [W-1:0] ext, // Outside level
	input wire logic [W-1:0] ext_en, // Outside drives
	output logic     [W-1:0] lvl // Pad level
);
	logic [W-1:0] flt = '0;
	// Floating pad wanders so stale levels fail
	always_ff @(posedge clk) flt <= ~flt;
	// Chip, then outside, then pull-up
	assign lvl = (~oe_n & out) | (oe_n & ext_en & ext) | (oe_n & ~ext_en & (pull | flt));
endmodule : gpm_board

// file: bench/gpm_pinmux_tb_top.sv
`timescale 1ns/1ps
`include "gpm_cfg.svh"
module gpm_pinmux_tb_top;
	logic        clk, rst, bus_wr, bus_rd, bus_wide, protected_write_permit, comparator_1_output;
	logic [15:0] bus_addr, aio_in, aio_out, aio_oe_n, aio_analog;
	logic [31:0] bus_wdata, bus_rdata, pin_a_in, pin_a_out, pin_a_oe_n, pin_a_pull_en, low_power_wake_sel;
	logic [6:0]  pin_b_in, pin_b_out, pin_b_oe_n, pin_b_pull_en;
	logic [7:0]  pwm_ch_out;
	logic        comparator_2_output, pwm_sync_out, serial_transmit, clock_output_pin, spi_data_out_in_o;
	logic        spi_data_out_in_drive, spi_data_in_out_o, spi_data_in_out_drive, spi_clock_pin_o;
	logic        spi_clock_pin_drive, spi_select_pin_o, spi_select_pin_drive, i2c_data_pin_low;
	logic        i2c_clock_pin_low, capture_pin_o, capture_pin_drive, pwm_sync_in, serial_receive;
	logic        trip_input_1, trip_input_2, trip_input_3, spi_data_out_in_i, spi_data_in_out_i;
	logic        spi_clock_pin_i, spi_select_pin_i, i2c_data_pin_i, i2c_clock_pin_i, capture_pin_i;
	logic        ext_irq_line_1, ext_irq_line_2, ext_irq_line_3;
	logic [31:0] s, ml, ea, d;
	int          n_fail = 0, checked = 0, n;
	logic [15:0] ra[$] = '{16'h6F80, 16'h6F84, 16'h6F86, 16'h6F88, 16'h6F8C, 16'h6F8E, 16'h6F96, 16'h6FB6,
		16'h6FC2, 16'h6FC6, 16'h6FCC, 16'h6FE0};
	int          pins[6] = '{0, 3, 12, 19, 28, 29};
	// Peripherals follow the random state
	assign {capture_pin_drive, capture_pin_o, i2c_clock_pin_low, i2c_data_pin_low, spi_select_pin_drive,
		spi_select_pin_o, spi_clock_pin_drive, spi_clock_pin_o, spi_data_in_out_drive, spi_data_in_out_o,
		spi_data_out_in_drive, spi_data_out_in_o, clock_output_pin, serial_transmit, pwm_sync_out,
		comparator_2_output, comparator_1_output, pwm_ch_out} = s[24:0];
	gpm_pinmux gpm_pinmux_inst (.*);
	gpm_board #(.W(32)) gpm_board_a (.clk(clk), .out(pin_a_out), .oe_n(pin_a_oe_n), .pull(pin_a_pull_en),
		.ext(ea), .ext_en(32'hFFFFFFFF), .lvl(pin_a_in));
	gpm_board #(.W(7)) gpm_board_b (.clk(clk), .out(pin_b_out), .oe_n(pin_b_oe_n), .pull(pin_b_pull_en),
		.ext(s[31:25]), .ext_en(~s[6:0]), .lvl(pin_b_in));
	gpm_board #(.W(16)) gpm_board_n (.clk(clk), .out(aio_out), .oe_n(aio_oe_n), .pull(s[15:0]),
		.ext(s[15:0]), .ext_en(s[31:16]), .lvl(aio_in));
	// Clock; watchdog at about 160 times the run
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial
	begin
		#200000;
		n_fail++;
		final_report();
	end
	function logic [31:0] nx();
		s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
		return s;
	endfunction : nx
	task chk(input string nm, input logic [31:0] e, input logic [31:0] v);
		checked++;
		if (v !== e)
		begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, e, v);
		end
	endtask : chk
	// Strobes held across one rising edge
	task wr(input logic [15:0] a, input logic [31:0] v, input logic w);
		@(negedge clk);
		bus_addr = a;
		bus_wdata = v;
		bus_wide = w;
		bus_wr = 1'b1;
		@(negedge clk);
		bus_wr = 1'b0;
	endtask : wr
	task rd(input logic [15:0] a, input logic [31:0] e);
		@(negedge clk);
		bus_addr = a;
		bus_wide = 1'b1;
		bus_rd = 1'b1;
		@(negedge clk);
		bus_rd = 1'b0;
		chk("rdata", e, bus_rdata);
	endtask : rd
	task final_report();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : final_report
	initial
	begin
		{rst, bus_wr, bus_rd, bus_wide, protected_write_permit} = 5'b10000;
		bus_addr = 16'h0000;
		bus_wdata = 32'h00000000;
		{s, ea, ml} = {32'h3A71, 64'h0};
		repeat (16) @(negedge clk);
		rst = 1'b0;
		foreach (ra[i])
			rd(ra[i], 32'h00000000);
		chk("pull", `GPM_A_IMPL, pin_a_pull_en);
		$display("test 1 done");
		d = nx() & `GPM_A_IMPL;
		for (int k = 0; k < 2; k++)
		begin
			protected_write_permit = k[0];
			wr(`GPM_A_DIR, d, 1'b1);
			wr(`GPM_WAKE, d, 1'b1);
			wr(`GPM_A_PUD, d, 1'b1);
			rd(`GPM_A_DIR, k ? d : 32'h0);
			rd(`GPM_WAKE, k ? d : 32'h0);
			chk("pull", k ? ~d & `GPM_A_IMPL : `GPM_A_IMPL, pin_a_pull_en);
		end
		wr(`GPM_A_PUD + 16'h0001, 32'h0000FFFF, 1'b0);
		chk("pull", ~d & `GPM_A_IMPL & 32'h0000FFFF, pin_a_pull_en);
		wr(`GPM_A_DIR, `GPM_A_IMPL, 1'b1);
		$display("test 2 done");
		for (int k = 0; k < 4; k++)
		begin
			d = nx();
			wr(`GPM_A_VAL + 16'(2 * k), d, 1'b1);
			ml = k == 0 ? d : k == 1 ? ml | d : k == 2 ? ml & ~d : ml ^ d;
			chk("latch", ml & `GPM_A_IMPL, pin_a_out & `GPM_A_IMPL);
		end
		d = nx();
		wr(`GPM_A_TOG + 16'h0001, d, 1'b0);
		ml = ml ^ {d[15:0], 16'h0000};
		chk("latch", ml & `GPM_A_IMPL, pin_a_out & `GPM_A_IMPL);
		repeat (6) @(negedge clk);
		rd(`GPM_A_VAL, ml & `GPM_A_IMPL);
		$display("test 3 done");
		wr(`GPM_A_MLO, 32'h0000655D, 1'b1);
		chk("old", ml & 32'hFF, pin_a_out & 32'hFF);
		repeat (2) @(negedge clk);
		chk("periph", {24'h0, s[7], 1'b0, s[5:2], s[8], s[0]}, pin_a_out & 32'hBF);
		rd(`GPM_A_MLO, 32'h0000655D);
		repeat (4) @(negedge clk);
		chk("sync_in", 32'h0, 32'(pwm_sync_in));
		wr(`GPM_A_MLO, 32'h0, 1'b1);
		wr(`GPM_A_DIR, 32'h0, 1'b1);
		$display("test 4 done");
		for (int k = 0; k < 3; k++)
		begin
			n = pins[nx() % 6];
			ea = nx();
			wr(`GPM_IRQ1 + 16'(k), 32'(n), 1'b0);
			repeat (8) @(negedge clk);
			chk("irq", 32'(ea[n]), 32'({ext_irq_line_3, ext_irq_line_2, ext_irq_line_1} >> k) & 32'h1);
		end
		$display("test 5 done");
		final_report();
	end
endmodule : gpm_pinmux_tb_top
